/* File: logic/owscr_regs.svh */
// Register offsets, field positions, reset values and timing counts of the window/config block.
`ifndef OWSCR_REGS_SVH
`define OWSCR_REGS_SVH

`define OWSCR_ADDR_WIN_SEL 8'h14
`define OWSCR_ADDR_WIN_STAT 8'h15
`define OWSCR_ADDR_SRC0 8'h1A
`define OWSCR_ADDR_SRC1 8'h1B
`define OWSCR_ADDR_FRAME_CFG 8'h3D

`define OWSCR_WIN_SEL_RESET 8'hE0
`define OWSCR_SRC_RESET 8'h00
`define OWSCR_FRAME_CFG_RESET 8'h00

`define OWSCR_CODE_LOADING 4'h0
`define OWSCR_CODE_OVERWRITTEN 4'h1
`define OWSCR_CODE_FIRST 4'hA

`define OWSCR_SRC_EN_BIT 7
`define OWSCR_SRC_ID_MSB 3
`define OWSCR_CFG_WIDTH_BIT 6
`define OWSCR_CFG_LEN_MSB 5
`define OWSCR_CFG_LEN_LSB 4
`define OWSCR_CFG_SEED_MSB 3

`define OWSCR_CRC8_POLY 8'h2F
`define OWSCR_CRC4_POLY 8'h01
`define OWSCR_CRC3_POLY 8'h03
`define OWSCR_CRC8_SEED 8'hFF
`define OWSCR_CRC4_SEED 8'h0A
`define OWSCR_CRC3_SEED 8'h07

`define OWSCR_BITS_NARROW 5'h0C
`define OWSCR_BITS_WIDE 5'h10

`define OWSCR_CLK_PERIOD_NS 25
`define OWSCR_SETTLE_NS 50000
`define OWSCR_SETTLE_CYC (`OWSCR_SETTLE_NS / `OWSCR_CLK_PERIOD_NS)

`endif

/* File: logic/owscr_pkg.sv */
// Types shared by the window/config block.
package owscr_pkg;

  typedef enum logic [1:0] {
    OWSCR_CRC_8,
    OWSCR_CRC_4,
    OWSCR_CRC_3
  } owscr_crc_len_t;

  typedef enum logic [1:0] {
    OWSCR_LD_IDLE,
    OWSCR_LD_FETCH,
    OWSCR_LD_STORE
  } owscr_ld_state_t;

endpackage

/* File: logic/owscr_load_if.sv */
// Handshake between the register core and the window loader.
`timescale 1ns/100ps
`default_nettype none

interface owscr_load_if;
  logic start;
  logic [3:0] code;
  logic busy;
  logic done;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;

  modport core (output start, output code, input busy, input done, input wr_en,
                input wr_idx, input wr_data);
  modport loader (input start, input code, output busy, output done, output wr_en,
                  output wr_idx, output wr_data);
endinterface

`default_nettype wire

/* File: logic/owscr_loader.sv */
// Loader that copies one sixteen-entry OTP range into the shared readable registers.
`timescale 1ns/100ps
`default_nettype none

module owscr_loader (
  input wire logic ref_clk, // Device clock.
  input wire logic rst_b, // Synchronous reset, active low.
  owscr_load_if.loader ld, // Start and write-back towards the core.
  output logic otp_rd_en, // OTP read strobe.
  output logic [7:0] otp_rd_addr, // OTP byte address.
  input wire logic [7:0] otp_rd_data // OTP data, valid one cycle after the strobe.
);

  owscr_pkg::owscr_ld_state_t state_r;
  owscr_pkg::owscr_ld_state_t state_nxt;
  logic [3:0] base_r;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic last_entry;

  //////////////////////////////////////////////////////////////////////////////
  // A fresh start always restarts from entry zero, even mid-load, so the
  // window never ends up holding a mix of two ranges.
  assign last_entry = (idx_r == 4'hF);
  assign ld.busy = (state_r != owscr_pkg::OWSCR_LD_IDLE);
  assign ld.wr_en = (state_r == owscr_pkg::OWSCR_LD_STORE) && !ld.start;
  assign ld.wr_idx = idx_r;
  assign ld.wr_data = otp_rd_data;
  assign ld.done = ld.wr_en && last_entry;
  assign otp_rd_en = (state_r == owscr_pkg::OWSCR_LD_FETCH);
  assign otp_rd_addr = {base_r, idx_r};

  // Next state of the fetch/store walk.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      owscr_pkg::OWSCR_LD_IDLE: begin
        state_nxt = owscr_pkg::OWSCR_LD_IDLE;
      end
      owscr_pkg::OWSCR_LD_FETCH: begin
        state_nxt = owscr_pkg::OWSCR_LD_STORE;
      end
      owscr_pkg::OWSCR_LD_STORE: begin
        state_nxt = last_entry ? owscr_pkg::OWSCR_LD_IDLE : owscr_pkg::OWSCR_LD_FETCH;
        idx_nxt = idx_r + 4'h1;
      end
      default: begin
        state_nxt = owscr_pkg::OWSCR_LD_IDLE;
      end
    endcase
    if (ld.start) begin
      state_nxt = owscr_pkg::OWSCR_LD_FETCH;
      idx_nxt = 4'h0;
    end
  end

  // State, index and range base.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= owscr_pkg::OWSCR_LD_IDLE;
      idx_r <= 4'h0;
      base_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      if (ld.start) begin
        base_r <= ld.code;
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/owscr_core.sv */
// Register core: OTP window, source mapping and serial frame configuration.
`include "owscr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module owscr_core #(
  parameter int SHARED_DEPTH = 16 // Entries of the shared window; must be 16.
) (
  input wire logic ref_clk, // Device clock, 40 MHz.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic i2c_mode, // High when the two-wire interface is in use.
  input wire logic init_done_lock, // High once initialisation is locked.
  input wire logic [7:0] reg_addr, // Register address from the protocol engine.
  input wire logic reg_wr_en, // One-cycle write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd_en, // One-cycle read strobe.
  output logic [7:0] reg_rdata, // Read data, registered.
  output logic reg_rd_valid, // Read data valid pulse.
  output logic wr_refused, // Pulse: a write was dropped by the lock.
  output logic otp_rd_en, // OTP read strobe.
  output logic [7:0] otp_rd_addr, // OTP byte address.
  input wire logic [7:0] otp_rd_data, // OTP data, one cycle after the strobe.
  output logic load_busy, // High while the window is being reloaded.
  input wire logic spi_cmd_start, // Pulse at the start of a serial command.
  output logic [4:0] frame_data_bits, // Data field width of the current frame.
  output owscr_pkg::owscr_crc_len_t frame_crc_len, // CRC length of the current frame.
  output logic [7:0] frame_crc_poly, // CRC polynomial, x^n term implied.
  output logic [7:0] frame_crc_seed, // CRC seed of the current frame.
  output logic [3:0] src0_id, // Source id zero; zero in two-wire mode.
  output logic src0_carries_data, // Source zero carries sensor channel zero.
  output logic src0_carries_err, // Source zero carries the error response.
  output logic [3:0] src1_id, // Source id one; zero in two-wire mode.
  output logic src1_carries_data, // Source one carries sensor channel one.
  output logic src1_carries_err, // Source one carries the error response.
  output logic [1:0] read_wrap_en, // Two-wire read wrap-around enables.
  output logic integrity_err // Sticky: a covered register changed unexpectedly.
);

  // The window index is a plain address nibble, so any other depth is refused.
  if (SHARED_DEPTH != 16) begin : g_depth_check
    $error("owscr_core: SHARED_DEPTH must be 16");
  end
  owscr_load_if ld_if ();
  owscr_loader u_loader (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ld(ld_if.loader),
    .otp_rd_en(otp_rd_en),
    .otp_rd_addr(otp_rd_addr),
    .otp_rd_data(otp_rd_data)
  );

  logic [7:0] shared_r [SHARED_DEPTH];
  logic [7:0] win_sel_r, src0_r, src1_r, cfg_r, reg_rdata_r;
  logic [3:0] stat_code_r, load_code_r;
  logic dirty_r, boot_pending_r, reg_rd_valid_r, wr_refused_r;
  logic [4:0] frame_bits_r;
  owscr_pkg::owscr_crc_len_t frame_len_r;
  logic [7:0] frame_poly_r, frame_seed_r, sig_r;
  logic sig_upd_r, integrity_err_r;
  logic [11:0] load_age_r;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and write qualification.
  logic wr_ok, sel_hit, stat_hit, src0_hit, src1_hit, cfg_hit, win_hit;
  logic sel_code_valid, load_start, host_win_wr, dirty_now;
  logic [3:0] start_code;
  logic [7:0] rd_win_val, rd_mux;
  assign wr_ok = reg_wr_en && !init_done_lock;
  assign sel_hit = (reg_addr == `OWSCR_ADDR_WIN_SEL);
  assign stat_hit = (reg_addr == `OWSCR_ADDR_WIN_STAT);
  assign src0_hit = (reg_addr == `OWSCR_ADDR_SRC0);
  assign src1_hit = (reg_addr == `OWSCR_ADDR_SRC1);
  assign cfg_hit = (reg_addr == `OWSCR_ADDR_FRAME_CFG);
  assign win_hit = (reg_addr[7:4] >= `OWSCR_CODE_FIRST);
  assign sel_code_valid = (reg_wdata[7:4] >= `OWSCR_CODE_FIRST);
  assign host_win_wr = wr_ok && win_hit;
  assign dirty_now = dirty_r || host_win_wr;
  // Reset comes up with the factory range selected, so fetch it once after release.
  assign load_start = (wr_ok && sel_hit && sel_code_valid) || boot_pending_r;
  assign start_code = boot_pending_r ? win_sel_r[7:4] : reg_wdata[7:4];
  assign ld_if.start = load_start;
  assign ld_if.code = start_code;
  assign load_busy = ld_if.busy;

  // Read selection; the window ignores the upper nibble on purpose.
  assign rd_win_val = shared_r[reg_addr[3:0]];
  assign rd_mux = win_hit ? rd_win_val :
                  sel_hit ? win_sel_r :
                  stat_hit ? {stat_code_r, 4'h0} :
                  src0_hit ? src0_r :
                  src1_hit ? src1_r :
                  cfg_hit ? cfg_r : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Shared window entries: the host write wins over the loader in the same cycle,
  // and the status then reports the overwrite.
  for (genvar gi = 0; gi < SHARED_DEPTH; gi++) begin : g_shared
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        shared_r[gi] <= 8'h00;
      end else if (host_win_wr && (reg_addr[3:0] == 4'(gi))) begin
        shared_r[gi] <= reg_wdata;
      end else if (ld_if.wr_en && (ld_if.wr_idx == 4'(gi))) begin
        shared_r[gi] <= ld_if.wr_data;
      end
    end
  end

  // Window select and the loader's progress.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      win_sel_r <= `OWSCR_WIN_SEL_RESET;
      boot_pending_r <= 1'b1;
      load_code_r <= 4'h0;
    end else begin
      boot_pending_r <= 1'b0;
      if (wr_ok && sel_hit) begin
        win_sel_r <= {reg_wdata[7:4], 4'h0};
      end
      if (load_start) begin
        load_code_r <= start_code;
      end
    end
  end

  // Status code; a host overwrite during a load is remembered for the end.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stat_code_r <= `OWSCR_CODE_LOADING;
      dirty_r <= 1'b0;
    end else if (load_start) begin
      stat_code_r <= `OWSCR_CODE_LOADING;
      dirty_r <= host_win_wr;
    end else if (ld_if.done) begin
      stat_code_r <= dirty_now ? `OWSCR_CODE_OVERWRITTEN : load_code_r;
      dirty_r <= 1'b0;
    end else if (host_win_wr) begin
      if (ld_if.busy) begin
        dirty_r <= 1'b1;
      end else begin
        stat_code_r <= `OWSCR_CODE_OVERWRITTEN;
      end
    end
  end

  // Source and frame configuration registers; reserved bits are stored as written.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      src0_r <= `OWSCR_SRC_RESET;
      src1_r <= `OWSCR_SRC_RESET;
      cfg_r <= `OWSCR_FRAME_CFG_RESET;
    end else if (wr_ok) begin
      if (src0_hit) begin
        src0_r <= reg_wdata;
      end
      if (src1_hit) begin
        src1_r <= reg_wdata;
      end
      if (cfg_hit) begin
        cfg_r <= reg_wdata;
      end
    end
  end

  // Read return and refusal pulse.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
      reg_rd_valid_r <= 1'b0;
      wr_refused_r <= 1'b0;
    end else begin
      reg_rd_valid_r <= reg_rd_en;
      wr_refused_r <= reg_wr_en && init_done_lock;
      if (reg_rd_en) begin
        reg_rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rd_valid = reg_rd_valid_r;
  assign wr_refused = wr_refused_r;

  //////////////////////////////////////////////////////////////////////////////
  // Frame parameters are decoded from the live register but only sampled at a
  // command start, so a write in mid-frame cannot corrupt the running CRC.
  logic [1:0] cfg_len;
  logic [3:0] cfg_seed;
  logic seed_zero;
  owscr_pkg::owscr_crc_len_t len_dec;
  logic [7:0] poly_dec, seed_dec;
  assign cfg_len = cfg_r[`OWSCR_CFG_LEN_MSB:`OWSCR_CFG_LEN_LSB];
  assign cfg_seed = cfg_r[`OWSCR_CFG_SEED_MSB:0];
  assign seed_zero = (cfg_seed == 4'h0);
  assign len_dec = (cfg_len == 2'b00) ? owscr_pkg::OWSCR_CRC_8 :
                   (cfg_len == 2'b01) ? owscr_pkg::OWSCR_CRC_4 :
                   owscr_pkg::OWSCR_CRC_3;
  assign poly_dec = (len_dec == owscr_pkg::OWSCR_CRC_8) ? `OWSCR_CRC8_POLY :
                    (len_dec == owscr_pkg::OWSCR_CRC_4) ? `OWSCR_CRC4_POLY :
                    `OWSCR_CRC3_POLY;
  assign seed_dec = (len_dec == owscr_pkg::OWSCR_CRC_8) ?
                      (seed_zero ? `OWSCR_CRC8_SEED : {4'h0, cfg_seed}) :
                    (len_dec == owscr_pkg::OWSCR_CRC_4) ?
                      (seed_zero ? `OWSCR_CRC4_SEED : {4'h0, cfg_seed}) :
                      (seed_zero ? `OWSCR_CRC3_SEED : {5'h00, cfg_seed[2:0]});

  // Frame parameter capture at the start of each serial command.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frame_bits_r <= `OWSCR_BITS_NARROW;
      frame_len_r <= owscr_pkg::OWSCR_CRC_8;
      frame_poly_r <= `OWSCR_CRC8_POLY;
      frame_seed_r <= `OWSCR_CRC8_SEED;
    end else if (spi_cmd_start) begin
      frame_bits_r <= cfg_r[`OWSCR_CFG_WIDTH_BIT] ? `OWSCR_BITS_WIDE : `OWSCR_BITS_NARROW;
      frame_len_r <= len_dec;
      frame_poly_r <= poly_dec;
      frame_seed_r <= seed_dec;
    end
  end

  assign frame_data_bits = frame_bits_r;
  assign frame_crc_len = frame_len_r;
  assign frame_crc_poly = frame_poly_r;
  assign frame_crc_seed = frame_seed_r;

  //////////////////////////////////////////////////////////////////////////////
  // Source mapping: the ids only steer the serial side; the two-wire side uses
  // the enables alone.
  assign src0_id = i2c_mode ? 4'h0 : src0_r[`OWSCR_SRC_ID_MSB:0];
  assign src1_id = i2c_mode ? 4'h0 : src1_r[`OWSCR_SRC_ID_MSB:0];
  assign src0_carries_data = !i2c_mode && src0_r[`OWSCR_SRC_EN_BIT];
  assign src0_carries_err = !i2c_mode && !src0_r[`OWSCR_SRC_EN_BIT];
  assign src1_carries_data = !i2c_mode && src1_r[`OWSCR_SRC_EN_BIT];
  assign src1_carries_err = !i2c_mode && !src1_r[`OWSCR_SRC_EN_BIT];
  assign read_wrap_en = i2c_mode ? {src1_r[`OWSCR_SRC_EN_BIT], src0_r[`OWSCR_SRC_EN_BIT]} :
                        2'b00;

  //////////////////////////////////////////////////////////////////////////////
  // Integrity signature: refreshed one cycle after each accepted write to a covered register, then
  // compared every cycle. Only a disturbance outside a write can trip it.
  logic [7:0] sig_calc;
  logic cov_wr;
  assign sig_calc = src0_r ^ {src1_r[6:0], src1_r[7]} ^ {cfg_r[5:0], cfg_r[7:6]} ^
                    {win_sel_r[4:0], win_sel_r[7:5]};
  assign cov_wr = wr_ok && (src0_hit || src1_hit || cfg_hit || sel_hit);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sig_upd_r <= 1'b1;
      sig_r <= 8'h00;
      integrity_err_r <= 1'b0;
    end else begin
      sig_upd_r <= cov_wr;
      if (sig_upd_r) begin
        sig_r <= sig_calc;
      end else if (sig_calc != sig_r) begin
        integrity_err_r <= 1'b1;
      end
    end
  end

  assign integrity_err = integrity_err_r;

  // Age of the running load, for the settle-time check below.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || load_start || !ld_if.busy) begin
      load_age_r <= 12'h000;
    end else begin
      load_age_r <= load_age_r + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_load_starts;
    wr_ok && sel_hit && sel_code_valid |=> stat_code_r == `OWSCR_CODE_LOADING && load_busy;
  endproperty
  a_load_starts: assert property (p_load_starts) else $error("load did not start");
  property p_done_code;
    ld_if.done && !dirty_now && !load_start |=> stat_code_r == $past(load_code_r);
  endproperty
  a_done_code: assert property (p_done_code) else $error("wrong active code");
  property p_overwrite;
    host_win_wr && !ld_if.busy && !load_start |=> stat_code_r == `OWSCR_CODE_OVERWRITTEN;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite not reported");
  property p_win_read;
    reg_rd_en && win_hit |=> reg_rd_valid && reg_rdata == $past(rd_win_val);
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read wrong");
  property p_lock;
    init_done_lock && reg_wr_en |=> $stable(cfg_r) && $stable(src0_r) && $stable(src1_r) &&
      $stable(win_sel_r) && wr_refused;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  property p_width;
    spi_cmd_start |=> frame_data_bits == ($past(cfg_r[6]) ? 5'h10 : 5'h0C);
  endproperty
  a_width: assert property (p_width) else $error("data width wrong");
  property p_seed8_default;
    spi_cmd_start && cfg_r[5:0] == 6'h00 |=> frame_crc_seed == 8'hFF && frame_crc_poly == 8'h2F;
  endproperty
  a_seed8_default: assert property (p_seed8_default) else $error("crc8 default wrong");
  property p_seed3;
    spi_cmd_start && cfg_r[5] && cfg_r[3:0] != 4'h0 |=>
      frame_crc_seed == {5'h00, $past(cfg_r[2:0])} && frame_crc_len == owscr_pkg::OWSCR_CRC_3;
  endproperty
  a_seed3: assert property (p_seed3) else $error("crc3 seed wrong");
  property p_frame_hold;
    !spi_cmd_start |=> $stable(frame_crc_seed) && $stable(frame_crc_poly) &&
      $stable(frame_data_bits);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame changed mid-command");
  property p_map;
    !i2c_mode |-> src1_carries_data == src1_r[7] && src1_carries_err == !src1_r[7] &&
      read_wrap_en == 2'b00;
  endproperty
  a_map: assert property (p_map) else $error("source map wrong");
  property p_i2c;
    i2c_mode |-> read_wrap_en == {src1_r[7], src0_r[7]} && !src0_carries_data &&
      !src0_carries_err && src0_id == 4'h0;
  endproperty
  a_i2c: assert property (p_i2c) else $error("two-wire source use wrong");
  property p_settle;
    load_age_r < 12'(`OWSCR_SETTLE_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("load too slow");
  property p_integrity;
    !integrity_err;
  endproperty
  a_integrity: assert property (p_integrity) else $error("integrity tripped");

  c_load_done: cover property (ld_if.done && !dirty_now);
  c_overwrite: cover property (host_win_wr && !ld_if.busy);
  c_refused: cover property (reg_wr_en && init_done_lock);
  c_crc3: cover property (spi_cmd_start && cfg_r[5]);

endmodule

`default_nettype wire

/* File: test/owscr_otp_model.sv */
// OTP array model that answers the window loader one cycle after each strobe.
`timescale 1ns/100ps
`default_nettype none

module owscr_otp_model (
  input wire logic ref_clk, // Device clock.
  input wire logic rd_en, // Read strobe from the loader.
  input wire logic [7:0] rd_addr, // OTP byte address.
  output logic [7:0] rd_data // Data, valid the cycle after the strobe.
);
  ////////////////////////////////////////////////////////////////////////////////
  // Contents are a fixed scramble of the address; outside a read the line toggles,
  // so a loader that samples late never happens to see the right byte.
  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= rd_addr ^ 8'h3C;
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule

`default_nettype wire

/* File: test/otp_window_spi_config_regs_tb_top.sv */
// Self-checking bench for the window, source and frame configuration register core.
`include "owscr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module otp_window_spi_config_regs_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic i2c_mode = 1'b0;
  logic init_done_lock = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic spi_cmd_start = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, otp_rd_addr, otp_rd_data, frame_crc_poly, frame_crc_seed;
  logic reg_rd_valid, wr_refused, otp_rd_en, load_busy, integrity_err;
  logic src0_carries_data, src0_carries_err, src1_carries_data, src1_carries_err;
  logic [4:0] frame_data_bits;
  logic [3:0] src0_id, src1_id;
  logic [1:0] read_wrap_en;
  owscr_pkg::owscr_crc_len_t frame_crc_len;
  logic [1:0] e_len;
  logic [7:0] e_poly;
  logic [7:0] e_seed = 8'hFF;
  logic [7:0] cfg_tab [9] = '{8'h00, 8'h45, 8'h10, 8'h1C, 8'h20, 8'h2D, 8'h30, 8'h7B, 8'h28};
  int n_errors = 0;
  int comparisons = 0;

  // Free-running 40 MHz device clock.
  always #12.5 ref_clk = ~ref_clk;

  owscr_core dut_u (.ref_clk, .rst_b, .i2c_mode, .init_done_lock, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid, .wr_refused, .otp_rd_en,
    .otp_rd_addr, .otp_rd_data, .load_busy, .spi_cmd_start, .frame_data_bits,
    .frame_crc_len, .frame_crc_poly, .frame_crc_seed, .src0_id, .src0_carries_data,
    .src0_carries_err, .src1_id, .src1_carries_data, .src1_carries_err, .read_wrap_en,
    .integrity_err);
  owscr_otp_model otp_u (.ref_clk, .rd_en(otp_rd_en), .rd_addr(otp_rd_addr),
    .rd_data(otp_rd_data));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and register access tasks.
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask

  // The strobe is taken at the second edge; the answer is looked at once it settles.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({7'h00, reg_rd_valid}, 8'h01);
    chk(reg_rdata, exp);
  endtask

  // A loader that never finishes would hang the run, so the wait is bounded.
  task automatic wait_idle;
    // Look a little after each edge so the flag is never read while it changes.
    for (int i = 0; i < 100 && load_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (load_busy !== 1'b0) begin
      n_errors++;
      $display("[FAIL] %0t window load never finished", $time);
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, window loads, sources, frame settings, then the lock.
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`OWSCR_ADDR_SRC0, 8'h00);
    rd(`OWSCR_ADDR_FRAME_CFG, 8'h00);
    rd(8'h40, 8'h00);
    wait_idle();
    rd(`OWSCR_ADDR_WIN_STAT, 8'hE0);
    for (int c = 10; c < 16; c++) begin
      wr(`OWSCR_ADDR_WIN_SEL, {c[3:0], 4'h0});
      #1;
      chk({7'h00, load_busy}, 8'h01);
      rd(`OWSCR_ADDR_WIN_STAT, 8'h00);
      wait_idle();
      repeat (`OWSCR_SETTLE_CYC) @(posedge ref_clk);
      rd(`OWSCR_ADDR_WIN_STAT, {c[3:0], 4'h0});
      for (int o = 0; o < 16; o += 15) begin
        rd({(c == 15) ? 4'hA : 4'hF, o[3:0]}, {c[3:0], o[3:0]} ^ 8'h3C);
      end
    end
    wr(8'hF3, 8'h55);
    rd(8'hA3, 8'h55);
    rd(`OWSCR_ADDR_WIN_STAT, 8'h10);
    wr(`OWSCR_ADDR_WIN_SEL, 8'h30);
    rd(`OWSCR_ADDR_WIN_SEL, 8'h30);
    // Source mapping in serial mode, then in two-wire mode.
    wr(`OWSCR_ADDR_SRC0, 8'h8B);
    wr(`OWSCR_ADDR_SRC1, 8'h75);
    #1;
    chk({src0_id, src0_carries_data, src0_carries_err, 2'h0}, 8'hB8);
    chk({src1_id, src1_carries_data, src1_carries_err, 2'h0}, 8'h54);
    rd(`OWSCR_ADDR_SRC1, 8'h75);
    @(posedge ref_clk);
    i2c_mode <= 1'b1;
    wr(`OWSCR_ADDR_SRC1, 8'h85);
    #1;
    chk({src0_id, src1_id}, 8'h00);
    chk({6'h00, read_wrap_en}, 8'h03);
    rd(`OWSCR_ADDR_SRC1, 8'h85);
    @(posedge ref_clk);
    i2c_mode <= 1'b0;
    // Each setting must wait for the next command before it reaches the frame.
    foreach (cfg_tab[i]) begin
      wr(`OWSCR_ADDR_FRAME_CFG, cfg_tab[i]);
      #1;
      chk(frame_crc_seed, e_seed);
      e_len = (cfg_tab[i][5:4] == 2'h0) ? 2'h0 : (cfg_tab[i][5:4] == 2'h1) ? 2'h1 : 2'h2;
      e_poly = (e_len == 2'h0) ? 8'h2F : (e_len == 2'h1) ? 8'h01 : 8'h03;
      if (cfg_tab[i][3:0] == 4'h0) begin
        e_seed = (e_len == 2'h0) ? 8'hFF : (e_len == 2'h1) ? 8'h0A : 8'h07;
      end else begin
        e_seed = (e_len == 2'h2) ? {5'h00, cfg_tab[i][2:0]} : {4'h0, cfg_tab[i][3:0]};
      end
      @(posedge ref_clk);
      spi_cmd_start <= 1'b1;
      @(posedge ref_clk);
      spi_cmd_start <= 1'b0;
      #1;
      chk({3'h0, frame_data_bits}, cfg_tab[i][6] ? 8'h10 : 8'h0C);
      chk({6'h00, frame_crc_len}, {6'h00, e_len});
      chk(frame_crc_poly, e_poly);
      chk(frame_crc_seed, e_seed);
    end
    // Once locked, writes are dropped and the current window stays in place.
    @(posedge ref_clk);
    init_done_lock <= 1'b1;
    wr(`OWSCR_ADDR_SRC0, 8'h00);
    #1;
    chk({7'h00, wr_refused}, 8'h01);
    wr(`OWSCR_ADDR_WIN_SEL, 8'hB0);
    #1;
    chk({7'h00, load_busy}, 8'h00);
    rd(`OWSCR_ADDR_SRC0, 8'h8B);
    rd(`OWSCR_ADDR_WIN_STAT, 8'h10);
    chk({7'h00, integrity_err}, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
